// [dv/adc_threshold_compare_assertions.sv]
`timescale 1ns/1ps
// ==========================================
// Bus handshake and flag causality checks.
module adc_threshold_compare_assertions #(
	parameter DEPTH = 16
) (
	// Clock and reset.
	input wire             ref_clk,
	input wire             rst_b,
	// Register bus.
	input wire [7:0]       avs_address,
	input wire             avs_read,
	input wire             avs_write,
	input wire [31:0]      avs_readdata,
	input wire             avs_waitrequest,
	// Conversion input and outputs.
	input wire             conv_valid,
	input wire             irq,
	input wire [DEPTH-1:0] channel_hit_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Completed writes, flag clears and sources that may raise the interrupt.
	wire wr_done = avs_write && !avs_waitrequest;
	wire hit_clr = wr_done && (avs_address == 8'h04);
	wire irq_src = conv_valid || (wr_done && (avs_address == 8'h0C));
	wire rd_done = avs_read && !avs_waitrequest;

	a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
		else $error("bus request not answered in time");
	a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("waitrequest low without a request");
	a_read_unmapped: assert property ((rd_done && avs_address == 8'h20) |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_hit_upper: assert property ((rd_done && avs_address == 8'h04) |-> avs_readdata[31:16] == 16'h0)
		else $error("upper hit word bits not zero");
	a_hit_sticky: assert property (
		|(~channel_hit_flag & $past(channel_hit_flag)) |-> $past(hit_clr) || $past(hit_clr, 2))
		else $error("hit flag fell without a clear");
	a_hit_cause: assert property (
		|(channel_hit_flag & ~$past(channel_hit_flag)) |-> $past(conv_valid, 2) || $past(conv_valid, 3))
		else $error("hit flag rose without a conversion");
	a_irq_rise: assert property ($rose(irq) |->
		$past(irq_src, 2) || $past(irq_src, 3) || $past(irq_src, 4))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
		else $error("interrupt fell without a write");
endmodule

bind adc_threshold_compare adc_threshold_compare_assertions #(.DEPTH(DEPTH)) u_chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.conv_valid(conv_valid), .irq(irq), .channel_hit_flag(channel_hit_flag));

// [dv/test_adc_threshold_compare.sv]
`timescale 1ns/1ps
// ==========================================
// Register level test of the compare stage.
module test_adc_threshold_compare;
	reg         ref_clk, rst_b, avs_read, avs_write, conv_valid;
	reg  [7:0]  avs_address;
	reg  [31:0] avs_writedata;
	reg  [3:0]  avs_byteenable, conv_channel;
	reg  [11:0] conv_result;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, irq;
	wire [15:0] channel_hit_flag;
	integer     err_count, tests_run, cyc;

	adc_threshold_compare u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid), .conv_channel(conv_channel),
		.conv_result(conv_result), .irq(irq), .channel_hit_flag(channel_hit_flag));

	// Free running clock.
	always #5 ref_clk = ~ref_clk;

	// Watchdog that cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			end_sim;
		end
	end

	// Prints the counts and the verdict.
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	// Compares a seen value with the expected one.
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// Buffer word address of a channel.
	function [7:0] ba(input [3:0] c);
		ba = {2'b01, c, 2'b00};
	endfunction

	// Bus write, held until waitrequest is sampled low.
	task bw(input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= 1'b1;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
			avs_write <= 1'b0;
		end
	endtask

	// Bus read, data taken at the completing edge.
	task br(input [7:0] a, input [31:0] e);
		begin
			@(posedge ref_clk);
			avs_address <= a;
			avs_read <= 1'b1;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
			chk(avs_readdata, e);
			avs_read <= 1'b0;
		end
	endtask

	// One conversion pulse, then time for flags and interrupt to settle.
	task conv(input [3:0] ch, input [11:0] r);
		begin
			@(posedge ref_clk);
			conv_valid <= 1'b1;
			conv_channel <= ch;
			conv_result <= r;
			@(posedge ref_clk);
			conv_valid <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
	endtask

	// Loads thresholds, converts once and checks flags, status and buffer.
	task run(input [1:0] cm, input [1:0] wm, input [3:0] ch, input [11:0] lo, input [11:0] hi,
		input [11:0] r);
		reg        own, up;
		reg [15:0] fl;
		reg [11:0] bo, bm;
		begin
			up = (cm == 2'h3) && (r > hi);
			case (cm)
				2'h0: own = r < lo;
				2'h1: own = r > lo;
				2'h2: own = (r > lo) && (r < hi);
				default: own = up || (r < lo);
			endcase
			own = own && (wm == 2'h1 || wm == 2'h2);
			fl = own ? ((16'h1 << ch) | (up ? (16'h1 << (ch ^ 4'h8)) : 16'h0)) : 16'h0;
			bo = (wm == 2'h0 || (own && wm == 2'h1 && !up)) ? r : lo;
			bm = (own && wm == 2'h1 && up) ? r : hi;
			bw(8'h00, 32'h0);
			bw(ba(ch), {20'h0, lo});
			bw(ba(ch ^ 4'h8), {20'h0, hi});
			bw(8'h04, 32'hFFFF);
			bw(8'h08, 32'h3);
			bw(8'h00, 32'h8010 | {28'h0, wm, cm});
			conv(ch, r);
			chk(channel_hit_flag, fl);
			chk(irq, |fl);
			br(8'h08, |fl);
			br(8'h04, fl);
			br(ba(ch), bo);
			br(ba(ch ^ 4'h8), bm);
			$display("compare case done at %0t", $time);
		end
	endtask

	// Main sequence.
	initial begin
		{ref_clk, rst_b, avs_read, avs_write, conv_valid} = 5'h0;
		{avs_address, avs_writedata, conv_channel, conv_result} = 56'h0;
		avs_byteenable = 4'hF;
		{err_count, tests_run, cyc} = 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		br(8'h00, 32'h0);
		br(8'h04, 32'h0);
		br(8'h08, 32'h0);
		br(8'h0C, 32'h0);
		chk(irq, 1'b0);
		bw(8'h20, 32'hFFFF);
		br(8'h20, 32'h0);
		avs_byteenable <= 4'h1;
		bw(8'h00, 32'hFFFF);
		avs_byteenable <= 4'hF;
		br(8'h00, 32'hFF);
		$display("reset and map test done");
		bw(8'h0C, 32'h1);
		run(2'h1, 2'h1, 4'h0, 12'h064, 12'h0, 12'h065);
		bw(8'h0C, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0);
		bw(8'h0C, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b1);
		bw(8'h08, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0);
		$display("interrupt mask test done");
		run(2'h1, 2'h1, 4'h0, 12'h064, 12'h0, 12'h064);
		run(2'h0, 2'h2, 4'h3, 12'h064, 12'h0, 12'h063);
		run(2'h0, 2'h1, 4'h3, 12'h064, 12'h0, 12'h064);
		run(2'h2, 2'h1, 4'h2, 12'h064, 12'h0C8, 12'h096);
		run(2'h2, 2'h2, 4'h2, 12'h064, 12'h0C8, 12'h096);
		run(2'h2, 2'h1, 4'h2, 12'h064, 12'h0C8, 12'h0C8);
		run(2'h3, 2'h1, 4'h2, 12'h064, 12'h0C8, 12'h0C9);
		run(2'h3, 2'h1, 4'h2, 12'h064, 12'h0C8, 12'h063);
		run(2'h3, 2'h2, 4'h1, 12'h064, 12'h0C8, 12'h12C);
		run(2'h3, 2'h1, 4'hA, 12'h064, 12'h0C8, 12'h0FA);
		run(2'h0, 2'h0, 4'h4, 12'h032, 12'h0, 12'h03C);
		run(2'h2, 2'h3, 4'h2, 12'h064, 12'h0C8, 12'h096);
		bw(8'h00, 32'h0);
		bw(ba(4'h1), 32'h0);
		bw(8'h04, 32'hFFFF);
		bw(8'h08, 32'h3);
		bw(8'h00, 32'h8019);
		bw(ba(4'h1), 32'h123);
		@(posedge ref_clk);
		conv_valid <= 1'b1;
		conv_channel <= 4'h1;
		conv_result <= 12'h200;
		@(posedge ref_clk);
		conv_channel <= 4'h5;
		@(posedge ref_clk);
		conv_valid <= 1'b0;
		repeat (6) @(posedge ref_clk);
		br(8'h08, 32'h3);
		br(8'h04, 32'h2);
		br(ba(4'h1), 32'h0);
		conv(4'h1, 12'h0);
		br(8'h04, 32'h2);
		bw(8'h04, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk(channel_hit_flag, 16'h0);
		$display("refusal and sticky test done");
		end_sim;
	end
endmodule

// [pkg/adc_threshold_compare_defines.vh]
`ifndef ADC_THRESHOLD_COMPARE_DEFINES_VH
`define ADC_THRESHOLD_COMPARE_DEFINES_VH

// ==========================================================
// Register byte offsets.
`define OFS_CONTROL     8'h00
`define OFS_HIT_LOW     8'h04
`define OFS_EVT_STATUS  8'h08
`define OFS_EVT_MASK    8'h0C
`define OFS_BUF_BASE    8'h40
`define BUF_SEL_MSB     7
`define BUF_SEL_LSB     6
`define BUF_IDX_LSB     2

// ==========================================================
// Control register fields.
`define CTL_CMP_LSB     0
`define CTL_DISP_LSB    2
`define CTL_INDEXED_BIT 4
`define CTL_ENABLE_BIT  15
`define CTL_RESET       16'h0000

// ==========================================================
// Compare and disposition encodings.
`define CMP_LESS        2'h0
`define CMP_GREATER     2'h1
`define CMP_INSIDE      2'h2
`define CMP_OUTSIDE     2'h3
`define DISP_LEGACY     2'h0
`define DISP_STORE      2'h1
`define DISP_DISCARD    2'h2

// ==========================================================
// Event status bits.
`define EVT_HIT_BIT     0
`define EVT_DROP_BIT    1
`define EVT_WIDTH       2
`define EVT_RESET       2'h0

`endif

// [verilog/adc_threshold_compare.v]
`timescale 1ns/1ps
`include "adc_threshold_compare_defines.vh"

// Operation
// - Mode 01 greater, 00 less, strict.
// - Simple match sets converted channel's flag.
// - Simple: disposition 01 stores, 10 drops.
// - Mode 10: strictly between both thresholds.
// - Inside match sets only own flag.
// - Inside: 01 overwrites lower, 10 drops.
// - Mode 11: above upper or below lower.
// - Above upper also sets mirrored flag.
// - Outside store goes to side crossed.
// - Mirrored locations are not protected.
// - Flags stay set until software clears.
// - Window modes pair lower, upper halves.
module adc_threshold_compare #(
	parameter W     = 12,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset.
	input  wire          ref_clk,
	input  wire          rst_b,
	// Avalon-MM slave.
	input  wire [7:0]    avs_address,
	input  wire          avs_read,
	input  wire          avs_write,
	input  wire [31:0]   avs_writedata,
	input  wire [3:0]    avs_byteenable,
	output reg  [31:0]   avs_readdata,
	output reg           avs_waitrequest,
	// Conversion results from the converter core.
	input  wire          conv_valid,
	input  wire [AW-1:0] conv_channel,
	input  wire [W-1:0]  conv_result,
	// Interrupt and flag view.
	output reg           irq,
	output reg  [DEPTH-1:0] channel_hit_flag
);

	// Window modes split the buffer in two halves; a location's upper
	// threshold sits at the same offset in the other half. Flipping the
	// top index bit gives that partner, so the pairing also works in
	// reverse: an upper channel reads a lower channel's slot as its upper threshold.
	localparam HALF = DEPTH / 2;

	// ==========================================================
	// Storage and control state.
	reg [W-1:0]     result_buffer_word [0:DEPTH-1];
	reg [15:0]      threshold_control_reg_q;
	reg [`EVT_WIDTH-1:0] evt_mask_q;
	reg             s1_valid_q;
	reg [AW-1:0]    s1_chan_q;
	reg [AW-1:0]    s1_mirror_q;
	reg [W-1:0]     s1_result_q;
	reg [W-1:0]     s1_lower_q;
	reg [W-1:0]     s1_upper_q;

	wire [1:0]      compare_select;
	wire [1:0]      result_disposition;
	wire            indexed_storage_select;
	wire            module_on;
	wire            req;
	wire            take;
	wire            is_buf;
	wire [AW-1:0]   buf_idx;
	wire [AW-1:0]   mirror_of;
	wire            window_mode;
	wire            accept;
	wire            dropped;
	wire            hit_own;
	wire            hit_mirror;
	wire            mirror_hit;
	wire [DEPTH-1:0] hit_flags_low_reg;
	wire [`EVT_WIDTH-1:0] evt_status;
	reg  [DEPTH-1:0] hit_set;
	reg  [DEPTH-1:0] hit_clr;
	reg  [`EVT_WIDTH-1:0] evt_set;
	reg  [`EVT_WIDTH-1:0] evt_clr;
	reg             wr_en;
	reg  [AW-1:0]   wr_addr;
	reg  [31:0]     rd_word;

	// Decodes a byte address into a buffer hit.
	function f_is_buf;
		input [7:0] a;
		begin
			f_is_buf = a[`BUF_SEL_MSB:`BUF_SEL_LSB] == 2'h1;
		end
	endfunction

	// Mirrored partner of a location, wrapping in the buffer.
	// It is used for every channel, upper ones included.
	function [AW-1:0] f_mirror;
		input [AW-1:0] c;
		begin
			f_mirror = c ^ HALF[AW-1:0];
		end
	endfunction

	// ==========================================================
	// Control field views.
	// Bit 4 is stored only; bit 15 gates the whole compare path.
	assign compare_select         = threshold_control_reg_q[`CTL_CMP_LSB +: 2];
	assign result_disposition     = threshold_control_reg_q[`CTL_DISP_LSB +: 2];
	assign indexed_storage_select = threshold_control_reg_q[`CTL_INDEXED_BIT];
	assign module_on              = threshold_control_reg_q[`CTL_ENABLE_BIT];
	assign window_mode            = compare_select[1];

	// ==========================================================
	// Bus decode: request held until waitrequest is seen low.
	// A request seen with waitrequest high turns waitrequest low for one
	// cycle; the master completes at the next edge, where take is high.
	// Every register side effect is gated by take, so a request still held
	// after its completing edge is taken again every second cycle.
	assign req     = avs_read | avs_write;
	assign take    = req & ~avs_waitrequest;
	assign is_buf  = f_is_buf(avs_address);
	assign buf_idx = avs_address[`BUF_IDX_LSB +: AW];

	// Waitrequest drops for one cycle, one cycle after a request.
	// Holding it high at idle means a request is never taken on the edge
	// where it first appears, which gives the read mux a full cycle.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else if (req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read mux; unmapped addresses read as zero.
	// Buffer words come back zero-extended to the bus width.
	always @* begin
		rd_word = 32'h00000000;
		if (is_buf) begin
			rd_word[W-1:0] = result_buffer_word[buf_idx];
		end else begin
			case (avs_address)
				`OFS_CONTROL:    rd_word[15:0] = threshold_control_reg_q;
				`OFS_HIT_LOW:    rd_word[DEPTH-1:0] = hit_flags_low_reg;
				`OFS_EVT_STATUS: rd_word[`EVT_WIDTH-1:0] = evt_status;
				`OFS_EVT_MASK:   rd_word[`EVT_WIDTH-1:0] = evt_mask_q;
				default:         rd_word = 32'h00000000;
			endcase
		end
	end

	// Read data is stable in the cycle that waitrequest is low.
	// It is captured on the edge that lowers waitrequest, so the master
	// finds it settled at the edge where it completes the read.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_word;
		end
	end

	// Control and mask writes honour the low byte lanes.
	// The indexed storage selection is kept for software to read back; the
	// buffer here is always channel indexed, so it steers nothing.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			threshold_control_reg_q <= `CTL_RESET;
			evt_mask_q              <= `EVT_RESET;
		end else if (take && avs_write) begin
			if (avs_address == `OFS_CONTROL) begin
				if (avs_byteenable[0]) begin
					threshold_control_reg_q[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					threshold_control_reg_q[15:8] <= avs_writedata[15:8];
				end
			end
			if (avs_address == `OFS_EVT_MASK && avs_byteenable[0]) begin
				evt_mask_q <= avs_writedata[`EVT_WIDTH-1:0];
			end
		end
	end

	// ==========================================================
	// Stage one: latch the conversion and both thresholds.
	// A conversion arriving while stage one is full is dropped.
	// The drop is reported as an event rather than queued, since a queue
	// would need a buffer and would delay every later compare.
	// Stage one blocks a new accept while it is full, so the next compare
	// reads its thresholds only after the previous store has landed.
	assign accept    = conv_valid & module_on & ~s1_valid_q;
	assign dropped   = conv_valid & module_on & s1_valid_q;
	assign mirror_of = f_mirror(conv_channel);

	// Upper channels use their partner too, unguarded.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_valid_q  <= 1'b0;
			s1_chan_q   <= {AW{1'b0}};
			s1_mirror_q <= {AW{1'b0}};
			s1_result_q <= {W{1'b0}};
			s1_lower_q  <= {W{1'b0}};
			s1_upper_q  <= {W{1'b0}};
		end else begin
			s1_valid_q <= accept;
			if (accept) begin
				s1_chan_q   <= conv_channel;
				s1_mirror_q <= mirror_of;
				s1_result_q <= conv_result;
				s1_lower_q  <= result_buffer_word[conv_channel];
				s1_upper_q  <= result_buffer_word[mirror_of];
			end
		end
	end

	// ==========================================================
	// Stage two: compare, then decide the single write.
	// The compare is combinational on the stage one registers, so flags
	// and the buffer store land one edge after the conversion was taken.
	threshold_match #(
		.W (W)
	) u_match (
		.compare_select (compare_select),
		.result         (s1_result_q),
		.lower          (s1_lower_q),
		.upper          (s1_upper_q),
		.hit_own        (hit_own),
		.hit_mirror     (hit_mirror)
	);

	// Only the outside-window mode may mark or store to the partner slot;
	// gating here keeps an inside-window match off the mirrored flag even
	// if the match logic were changed later.
	assign mirror_hit = window_mode & compare_select[0] & hit_mirror;

	// Hit flags and buffer write follow the compare outcome.
	// Legacy disposition stores every result at its own channel without a
	// compare and marks nothing. Disposition 11 is reserved and does nothing.
	// A store goes to exactly one location: the partner slot when the result
	// crossed the upper threshold, otherwise the converted channel's slot.
	always @* begin
		hit_set = {DEPTH{1'b0}};
		wr_en   = 1'b0;
		wr_addr = s1_chan_q;
		if (s1_valid_q) begin
			case (result_disposition)
				`DISP_LEGACY: begin
					wr_en = 1'b1;
				end
				`DISP_STORE, `DISP_DISCARD: begin
					if (hit_own) begin
						hit_set[s1_chan_q] = 1'b1;
						if (mirror_hit) begin
							hit_set[s1_mirror_q] = 1'b1;
						end
						if (result_disposition == `DISP_STORE) begin
							wr_en = 1'b1;
							if (mirror_hit) begin
								wr_addr = s1_mirror_q;
							end
						end
					end
				end
				default: begin
					wr_en = 1'b0;
				end
			endcase
		end
	end

	// One buffer location per conversion, or a bus load while off.
	// The array has no reset; its words are undefined until loaded, and a
	// store pending from stage two always drains before a bus load can land.
	always @(posedge ref_clk) begin
		if (wr_en) begin
			result_buffer_word[wr_addr] <= s1_result_q;
		end else if (take && avs_write && is_buf && !module_on) begin
			result_buffer_word[buf_idx] <= avs_writedata[W-1:0];
		end
	end

	// ==========================================================
	// Sticky flags and events.
	// Hit flags and event bits are cleared by writing ones. A hardware set
	// in the same cycle as a clear wins inside the flag bank, so software
	// that clears right after reading can never lose a fresh hit.
	// Event bit 0 records any hit, bit 1 a conversion lost to a busy stage.
	// Clears come only from a completed write to the matching offset.
	always @* begin
		hit_clr = {DEPTH{1'b0}};
		evt_clr = {`EVT_WIDTH{1'b0}};
		if (take && avs_write && avs_address == `OFS_HIT_LOW) begin
			hit_clr = avs_writedata[DEPTH-1:0];
		end
		if (take && avs_write && avs_address == `OFS_EVT_STATUS) begin
			evt_clr = avs_writedata[`EVT_WIDTH-1:0];
		end
		evt_set = {`EVT_WIDTH{1'b0}};
		evt_set[`EVT_HIT_BIT]  = |hit_set;
		evt_set[`EVT_DROP_BIT] = dropped;
	end

	sticky_flags #(
		.N (DEPTH)
	) u_hits (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.set_in  (hit_set),
		.clr_in  (hit_clr),
		.flags   (hit_flags_low_reg)
	);

	sticky_flags #(
		.N (`EVT_WIDTH)
	) u_events (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.set_in  (evt_set),
		.clr_in  (evt_clr),
		.flags   (evt_status)
	);

	// Registered interrupt and flag view.
	// Both outputs lag the flag bank by one cycle so each comes from a
	// flip-flop; the interrupt is a level and falls once the causing bits
	// are cleared or masked.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq              <= 1'b0;
			channel_hit_flag <= {DEPTH{1'b0}};
		end else begin
			irq              <= |(evt_status & evt_mask_q);
			channel_hit_flag <= hit_flags_low_reg;
		end
	end

endmodule

// [verilog/sticky_flags.v]
`timescale 1ns/1ps

// Bank of sticky flags: set by hardware, cleared by writing one.
module sticky_flags #(
	parameter N = 16
) (
	// Clock and reset.
	input  wire         ref_clk,
	input  wire         rst_b,
	// Set and clear strobes.
	input  wire [N-1:0] set_in,
	input  wire [N-1:0] clr_in,
	// Flag state.
	output wire [N-1:0] flags
);

	genvar i;

	// A set in the same cycle as a clear wins, so no event is lost.
	generate
		for (i = 0; i < N; i = i + 1) begin : g_flag
			reg flag_q;
			always @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					flag_q <= 1'b0;
				end else if (set_in[i]) begin
					flag_q <= 1'b1;
				end else if (clr_in[i]) begin
					flag_q <= 1'b0;
				end
			end
			assign flags[i] = flag_q;
		end
	endgenerate

endmodule

// [verilog/threshold_match.v]
`timescale 1ns/1ps
`include "adc_threshold_compare_defines.vh"

// Decides the outcome of one compare for the selected mode.
module threshold_match #(
	parameter W = 12
) (
	// Mode and operands.
	input  wire [1:0]   compare_select,
	input  wire [W-1:0] result,
	input  wire [W-1:0] lower,
	input  wire [W-1:0] upper,
	// Outcome.
	output reg          hit_own,
	output reg          hit_mirror
);

	wire above_upper;
	wire below_lower;
	wire above_lower;
	wire below_upper;

	// Every comparison is strict.
	assign above_upper = result > upper;
	assign below_lower = result < lower;
	assign above_lower = result > lower;
	assign below_upper = result < upper;

	// Outcome per mode; the mirror hit exists only above the upper bound.
	always @* begin
		hit_own    = 1'b0;
		hit_mirror = 1'b0;
		case (compare_select)
			`CMP_GREATER: hit_own = above_lower;
			`CMP_LESS:    hit_own = below_lower;
			`CMP_INSIDE:  hit_own = above_lower & below_upper;
			`CMP_OUTSIDE: begin
				hit_own    = above_upper | below_lower;
				hit_mirror = above_upper;
			end
			default: hit_own = 1'b0;
		endcase
	end

endmodule
